// ===== rtl/ppc_port_config.sv
// Port pin configuration block with APB register access
//
// Summary of operation
// - Three 8-bit ports and a 2-bit fourth port give 26 pins in all.
// - Each free pin other than the bus and reset pins of port 1 takes one of four output types from two cfg registers.
// - The shared reset pin bit of port 1 is always input-only.
// - The bus clock and data pins of port 1 allow input-only or open-drain.
// - Quasi-bidirectional drives a high latch weakly and a low one strongly.
// - Open-drain has no pull-up and sinks only while the latch holds 0.
// - Input-only enables no driver and leaves the input readable.
// - Push-pull drives the latch value strongly both high and low.
// - Every pin input is filtered against glitches before logic reads it.
// - Bits 1 to 5 of the digital input disable register gate port-0 inputs.
// - All pins come out of reset as input-only.
// - Clock and reset options take pins away, leaving 26 down to 23.
// - With reset pin enable set the shared pin is an active-low reset.
//
// Implementation choices: the address map and register access over APB.
`timescale 1ns/10ps
`default_nettype none
`include "ppc_defs.svh"
module ppc_port_config (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [25:0] pin_in,
    output logic [25:0] pin_out,
    output logic [25:0] pin_oe_n,
    output logic [25:0] pin_weak_pullup,
    output logic ext_reset_n,
    output logic counter0_input,
    output logic external_irq0_input
);
    import ppc_pkg::*;

    // Type of one pin from its cfg bit pair, taken pins forced input-only
    function automatic ppc_pin_type_t pin_type(
        input logic c1,
        input logic c2,
        input logic taken
    );
        ppc_pin_type_t t;
        t = ppc_pin_type_t'({c1, c2});
        if (taken)
        begin
            t = PPC_INPUT_ONLY;
        end
        return t;
    endfunction

    // Eight bits of one port out of a flat pin vector
    function automatic logic [7:0] port_get(
        input logic [25:0] v,
        input logic [1:0] p
    );
        logic [7:0] r;
        r = 8'h00;
        if (p == 2'h0)
        begin
            r = v[7:0];
        end
        else if (p == 2'h1)
        begin
            r = v[15:8];
        end
        else if (p == 2'h2)
        begin
            r = v[23:16];
        end
        else
        begin
            r = {6'h00, v[25:24]};
        end
        return r;
    endfunction

    // Flat pin vector with one port replaced
    function automatic logic [25:0] port_put(
        input logic [25:0] v,
        input logic [1:0] p,
        input logic [7:0] d
    );
        logic [25:0] r;
        r = v;
        if (p == 2'h0)
        begin
            r[7:0] = d;
        end
        else if (p == 2'h1)
        begin
            r[15:8] = d;
        end
        else if (p == 2'h2)
        begin
            r[23:16] = d;
        end
        else
        begin
            r[25:24] = d[1:0];
        end
        return r;
    endfunction

    ppc_pin_if pins ();

    ppc_pin_filter u_filter (
        .pclk (pclk),
        .presetn (presetn),
        .pins (pins)
    );

    assign pins.raw = pin_in;

    // Register state
    logic [25:0] latch_reg;
    logic [25:0] latch_next;
    logic [25:0] cfg1_reg;
    logic [25:0] cfg1_next;
    logic [25:0] cfg2_reg;
    logic [25:0] cfg2_next;
    logic [7:0] dis_reg;
    logic [7:0] dis_next;
    logic [7:0] sys_reg;
    logic [7:0] sys_next;
    logic [31:0] rdata_reg;
    logic [31:0] rdata_next;
    logic err_reg;
    logic err_next;

    // Pin driver state
    logic [25:0] out_reg;
    logic [25:0] out_next;
    logic [25:0] oe_n_reg;
    logic [25:0] oe_n_next;
    logic [25:0] weak_reg;
    logic [25:0] weak_next;
    logic rst_n_reg;
    logic rst_n_next;

    logic reset_pin_enable;
    ppc_clk_src_t clk_src;
    logic [25:0] taken;
    logic [25:0] pin_view;
    logic [2:0] lost;
    logic [4:0] io_count;
    logic setup;
    logic wr_access;
    logic [1:0] port_sel;
    logic [1:0] fld_sel;
    logic [7:0] wbyte;

    assign reset_pin_enable = sys_reg[`PPC_SYS_RPE];
    assign clk_src = ppc_clk_src_t'(sys_reg[`PPC_SYS_CLK_HI:`PPC_SYS_CLK_LO]);
    assign setup = psel && !penable;
    assign wr_access = psel && penable && pwrite && pstrb[0] && !err_reg;
    assign port_sel = paddr[5:4];
    assign fld_sel = paddr[3:2];
    assign wbyte = pwdata[7:0];

    // Pins lost to clock and reset options
    always_comb
    begin
        taken = 26'h0000000;
        taken[`PPC_PIN_RST] = reset_pin_enable;
        if (clk_src == PPC_CLK_EXTERNAL)
        begin
            taken[`PPC_PIN_XTAL1] = 1'b1;
        end
        else if (clk_src == PPC_CLK_CRYSTAL)
        begin
            taken[`PPC_PIN_XTAL1] = 1'b1;
            taken[`PPC_PIN_XTAL2] = 1'b1;
        end
        lost = {2'h0, taken[`PPC_PIN_RST]}
            + {2'h0, taken[`PPC_PIN_XTAL1]}
            + {2'h0, taken[`PPC_PIN_XTAL2]};
        io_count = `PPC_IO_MAX - {2'h0, lost};
    end

    // Digital input as software sees it
    always_comb
    begin
        pin_view = pins.clean & ~taken;
        pin_view[7:0] = pins.clean[7:0] & ~dis_reg & ~taken[7:0];
    end

    // APB register file
    always_comb
    begin
        latch_next = latch_reg;
        cfg1_next = cfg1_reg;
        cfg2_next = cfg2_reg;
        dis_next = dis_reg;
        sys_next = sys_reg;
        rdata_next = rdata_reg;
        err_next = err_reg;
        if (setup)
        begin
            rdata_next = 32'h00000000;
            err_next = 1'b0;
            if (paddr[1:0] != 2'h0)
            begin
                err_next = 1'b1;
            end
            else if (paddr < `PPC_PORT_TOP)
            begin
                if (fld_sel == `PPC_FLD_LATCH)
                begin
                    rdata_next[7:0] = port_get(latch_reg, port_sel);
                end
                else if (fld_sel == `PPC_FLD_CFG1)
                begin
                    rdata_next[7:0] = port_get(cfg1_reg, port_sel);
                end
                else if (fld_sel == `PPC_FLD_CFG2)
                begin
                    rdata_next[7:0] = port_get(cfg2_reg, port_sel);
                end
                else
                begin
                    rdata_next[7:0] = port_get(pin_view, port_sel);
                    err_next = pwrite;
                end
            end
            else if (paddr == `PPC_OFF_DIS)
            begin
                rdata_next[7:0] = dis_reg;
            end
            else if (paddr == `PPC_OFF_SYS)
            begin
                rdata_next[7:0] = sys_reg;
            end
            else if (paddr == `PPC_OFF_STAT)
            begin
                rdata_next[4:0] = io_count;
                rdata_next[8] = reset_pin_enable;
                err_next = pwrite;
            end
            else
            begin
                err_next = 1'b1;
            end
        end
        if (wr_access)
        begin
            if (paddr < `PPC_PORT_TOP)
            begin
                if (fld_sel == `PPC_FLD_LATCH)
                begin
                    latch_next = port_put(latch_reg, port_sel, wbyte);
                end
                else if (fld_sel == `PPC_FLD_CFG1)
                begin
                    cfg1_next = port_put(cfg1_reg, port_sel, wbyte);
                    cfg1_next = cfg1_next | `PPC_OD_ONLY_MASK;
                    cfg1_next = cfg1_next | `PPC_RST_MASK;
                end
                else if (fld_sel == `PPC_FLD_CFG2)
                begin
                    cfg2_next = port_put(cfg2_reg, port_sel, wbyte);
                    cfg2_next = cfg2_next & ~`PPC_RST_MASK;
                end
            end
            else if (paddr == `PPC_OFF_DIS)
            begin
                dis_next = wbyte & `PPC_DIS_MASK;
            end
            else if (paddr == `PPC_OFF_SYS)
            begin
                sys_next = {5'h00, wbyte[2:0]};
            end
        end
    end

    // Pin drivers: strong drive on oe_n low; with oe_n high, weak pull-up only for a quasi-bidirectional high latch
    always_comb
    begin
        out_next = 26'h0000000;
        oe_n_next = 26'h3ffffff;
        weak_next = 26'h0000000;
        for (int i = 0; i < `PPC_NPINS; i++)
        begin
            case (pin_type(cfg1_reg[i], cfg2_reg[i], taken[i]))
                PPC_QUASI:
                begin
                    out_next[i] = latch_reg[i];
                    oe_n_next[i] = latch_reg[i];
                    weak_next[i] = latch_reg[i];
                end
                PPC_PUSH_PULL:
                begin
                    out_next[i] = latch_reg[i];
                    oe_n_next[i] = 1'b0;
                end
                PPC_OPEN_DRAIN:
                begin
                    out_next[i] = 1'b0;
                    oe_n_next[i] = latch_reg[i];
                end
                default:
                begin
                    oe_n_next[i] = 1'b1;
                end
            endcase
        end
        rst_n_next = 1'b1;
        if (reset_pin_enable)
        begin
            rst_n_next = pins.clean[`PPC_PIN_RST];
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            latch_reg <= `PPC_LATCH_RST;
            cfg1_reg <= `PPC_CFG1_RST;
            cfg2_reg <= `PPC_CFG2_RST;
            dis_reg <= `PPC_DIS_RST;
            sys_reg <= `PPC_SYS_RST;
            rdata_reg <= 32'h00000000;
            err_reg <= 1'b0;
            out_reg <= 26'h0000000;
            oe_n_reg <= 26'h3ffffff;
            weak_reg <= 26'h0000000;
            rst_n_reg <= 1'b1;
        end
        else
        begin
            latch_reg <= latch_next;
            cfg1_reg <= cfg1_next;
            cfg2_reg <= cfg2_next;
            dis_reg <= dis_next;
            sys_reg <= sys_next;
            rdata_reg <= rdata_next;
            err_reg <= err_next;
            out_reg <= out_next;
            oe_n_reg <= oe_n_next;
            weak_reg <= weak_next;
            rst_n_reg <= rst_n_next;
        end
    end

    assign prdata = rdata_reg;
    assign pready = psel && penable;
    assign pslverr = psel && penable && err_reg;
    assign pin_out = out_reg;
    assign pin_oe_n = oe_n_reg;
    assign pin_weak_pullup = weak_reg;
    assign ext_reset_n = rst_n_reg;
    assign counter0_input = pins.clean[`PPC_PIN_BUS_CLK];
    assign external_irq0_input = pins.clean[`PPC_PIN_BUS_DATA];

endmodule
`default_nettype wire

// ===== rtl/ppc_defs.svh
// Offsets, field positions, reset values and timing of the port block
`ifndef PPC_DEFS_SVH
`define PPC_DEFS_SVH

`define PPC_NPINS 26
`define PPC_ADDR_W 12

// Port register group: port number in paddr[5:4], field in paddr[3:2]
`define PPC_PORT_TOP 12'h040
`define PPC_FLD_LATCH 2'h0
`define PPC_FLD_CFG1 2'h1
`define PPC_FLD_CFG2 2'h2
`define PPC_FLD_PINS 2'h3
`define PPC_OFF_DIS 12'h040
`define PPC_OFF_SYS 12'h044
`define PPC_OFF_STAT 12'h048

// Reset values
`define PPC_CFG1_RST 26'h3ffffff
`define PPC_CFG2_RST 26'h0000000
`define PPC_LATCH_RST 26'h3ffffff
`define PPC_DIS_RST 8'h00
`define PPC_DIS_MASK 8'h3e
`define PPC_SYS_RST 8'h00

// System register fields
`define PPC_SYS_RPE 0
`define PPC_SYS_CLK_HI 2
`define PPC_SYS_CLK_LO 1

// Pin indexes in the flat pin vector (port*8 + bit)
`define PPC_PIN_BUS_CLK 10
`define PPC_PIN_BUS_DATA 11
`define PPC_PIN_RST 13
`define PPC_PIN_XTAL2 24
`define PPC_PIN_XTAL1 25
`define PPC_OD_ONLY_MASK 26'h0000c00
`define PPC_RST_MASK 26'h0002000
`define PPC_IO_MAX 5'h1a

// Input glitch suppression
`define PPC_CLK_PERIOD_NS 10
`define PPC_GLITCH_NS 30
`define PPC_GLITCH_CYC \
    ((`PPC_GLITCH_NS + `PPC_CLK_PERIOD_NS - 1) / `PPC_CLK_PERIOD_NS)

`endif

// ===== rtl/ppc_pkg.sv
// Types shared by the port block
package ppc_pkg;

    typedef enum logic [1:0] {
        PPC_QUASI = 2'h0,
        PPC_PUSH_PULL = 2'h1,
        PPC_INPUT_ONLY = 2'h2,
        PPC_OPEN_DRAIN = 2'h3
    } ppc_pin_type_t;

    typedef enum logic [1:0] {
        PPC_CLK_ON_CHIP = 2'h0,
        PPC_CLK_EXTERNAL = 2'h1,
        PPC_CLK_CRYSTAL = 2'h3,
        PPC_CLK_SPARE = 2'h2
    } ppc_clk_src_t;

endpackage

// ===== rtl/ppc_pin_if.sv
// Raw and cleaned pin levels between core and input filter
`timescale 1ns/10ps
`default_nettype none
interface ppc_pin_if;
    logic [25:0] raw;
    logic [25:0] clean;
    modport filt (input raw, output clean);
    modport core (output raw, input clean);
endinterface
`default_nettype wire

// ===== rtl/ppc_pin_filter.sv
// Synchroniser and glitch filter for every pin input
`timescale 1ns/10ps
`default_nettype none
`include "ppc_defs.svh"
module ppc_pin_filter (
    input wire logic pclk,
    input wire logic presetn,
    ppc_pin_if.filt pins
);
    import ppc_pkg::*;

    localparam logic [1:0] GLITCH_LIM = 2'(`PPC_GLITCH_CYC - 1);

    genvar gi;
    generate
        for (gi = 0; gi < `PPC_NPINS; gi++)
        begin : g_pin
            logic sync1_reg;
            logic sync2_reg;
            logic clean_reg;
            logic clean_next;
            logic [1:0] cnt_reg;
            logic [1:0] cnt_next;

            // Level must hold for the whole window before it is taken
            always_comb
            begin
                clean_next = clean_reg;
                cnt_next = 2'h0;
                if (sync2_reg != clean_reg)
                begin
                    if (cnt_reg == GLITCH_LIM)
                    begin
                        clean_next = sync2_reg;
                    end
                    else
                    begin
                        cnt_next = cnt_reg + 2'h1;
                    end
                end
            end

            always_ff @(posedge pclk or negedge presetn)
            begin
                if (!presetn)
                begin
                    sync1_reg <= 1'b1;
                    sync2_reg <= 1'b1;
                    clean_reg <= 1'b1;
                    cnt_reg <= 2'h0;
                end
                else
                begin
                    sync1_reg <= pins.raw[gi];
                    sync2_reg <= sync1_reg;
                    clean_reg <= clean_next;
                    cnt_reg <= cnt_next;
                end
            end

            assign pins.clean[gi] = clean_reg;
        end
    endgenerate
endmodule
`default_nettype wire

// ===== tb/ppc_port_config_asserts.sv
// Timing and pin-drive checks on the port block's top ports
`timescale 1ns/10ps
`default_nettype none
module ppc_port_config_asserts (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic [25:0] pin_in,
    input wire logic [25:0] pin_out,
    input wire logic [25:0] pin_oe_n,
    input wire logic [25:0] pin_weak_pullup,
    input wire logic ext_reset_n,
    input wire logic counter0_input
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    property p_zero_wait;
        psel && penable |-> pready;
    endproperty
    a_zero_wait: assert property (p_zero_wait) else $error("ready late");
    property p_err_in_access;
        pslverr |-> psel && penable;
    endproperty
    a_err_in_access: assert property (p_err_in_access) else $error("stray err");
    property p_rst_pin_input;
        pin_oe_n[13] && !pin_weak_pullup[13];
    endproperty
    a_rst_pin_input: assert property (p_rst_pin_input) else $error("pin 13");
    property p_bus_pins_od;
        pin_weak_pullup[11:10] == 2'h0 && (pin_out[11:10] & ~pin_oe_n[11:10]) == 2'h0;
    endproperty
    a_bus_pins_od: assert property (p_bus_pins_od) else $error("bus pin");
    property p_weak_high;
        (pin_weak_pullup & ~pin_oe_n) == 26'h0;
    endproperty
    a_weak_high: assert property (p_weak_high) else $error("weak+strong");
    property p_reset_inputs;
        $rose(presetn) |-> (&pin_oe_n && pin_weak_pullup == 26'h0) [*2];
    endproperty
    a_reset_inputs: assert property (p_reset_inputs) else $error("not input");
    property p_glitch;
        $changed(counter0_input) |-> $past(pin_in[10], 5) == counter0_input;
    endproperty
    a_glitch: assert property (p_glitch) else $error("unfiltered");
    property p_ext_reset;
        $fell(ext_reset_n) |-> !$past(pin_in[13], 5);
    endproperty
    a_ext_reset: assert property (p_ext_reset) else $error("reset pin");
endmodule
bind ppc_port_config ppc_port_config_asserts ppc_port_config_asserts_i (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pready(pready), .pslverr(pslverr), .pin_in(pin_in), .pin_out(pin_out),
    .pin_oe_n(pin_oe_n), .pin_weak_pullup(pin_weak_pullup),
    .ext_reset_n(ext_reset_n), .counter0_input(counter0_input)
);
`default_nettype wire

// ===== tb/ppc_board.sv
// Board model: pull-ups, external drivers and floating pins
`timescale 1ns/10ps
`default_nettype none
module ppc_board #(
    parameter logic [25:0] PULLUP = 26'h0002c00
) (
    input wire logic pclk,
    input wire logic [25:0] pin_out,
    input wire logic [25:0] pin_oe_n,
    input wire logic [25:0] pin_weak_pullup,
    input wire logic [25:0] ext_en,
    input wire logic [25:0] ext_val,
    output logic [25:0] pin_in
);
    logic [25:0] flt = 26'h0;
    // Undriven pins wander every cycle
    always @(posedge pclk)
        flt <= ~flt;
    always_comb
    begin
        for (int i = 0; i < 26; i++)
        begin
            if (!pin_oe_n[i])
                pin_in[i] = pin_out[i];
            else if (ext_en[i])
                pin_in[i] = ext_val[i];
            else if (pin_weak_pullup[i] || PULLUP[i])
                pin_in[i] = 1'b1;
            else
                pin_in[i] = flt[i];
        end
    end
endmodule
`default_nettype wire

// ===== tb/tb_ppc_port_config.sv
// Self-checking bench for the port pin configuration block
`timescale 1ns/10ps
`default_nettype none
module tb_ppc_port_config;
    typedef struct {logic [32:0] v; logic [32:0] m;} ppc_exp_t;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h0;
    logic [31:0] pwdata = 32'h0;
    logic [3:0] pstrb = 4'hf;
    logic [31:0] prdata;
    logic pready, pslverr, ext_reset_n, counter0_input, external_irq0_input;
    logic [25:0] pin_in, pin_out, pin_oe_n, pin_weak_pullup;
    logic [25:0] ext_en = 26'h0;
    logic [25:0] ext_val = 26'h0;
    ppc_exp_t expq[$];
    int fails = 0;
    int num_checks = 0;
    always #5 pclk = ~pclk;
    ppc_port_config ppc_port_config_i (.pclk(pclk), .presetn(presetn),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .pin_in(pin_in), .pin_out(pin_out),
        .pin_oe_n(pin_oe_n), .pin_weak_pullup(pin_weak_pullup),
        .ext_reset_n(ext_reset_n), .counter0_input(counter0_input),
        .external_irq0_input(external_irq0_input));
    ppc_board ppc_board_i (.pclk(pclk), .pin_out(pin_out),
        .pin_oe_n(pin_oe_n), .pin_weak_pullup(pin_weak_pullup),
        .ext_en(ext_en), .ext_val(ext_val), .pin_in(pin_in));
    task automatic chk(input logic ok, input string msg);
        num_checks++;
        if (ok !== 1'b1)
        begin
            fails++;
            $display("[FAIL] %0t %s", $time, msg);
        end
    endtask
    task automatic finish_test();
        $display("checks %0d mismatches %0d", num_checks, fails);
        if (fails == 0 && num_checks > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    task automatic apb(input logic w, input logic [11:0] a,
            input logic [31:0] d, input logic [32:0] ev, input logic [32:0] em);
        int n;
        expq.push_back('{ev, em});
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        n = 0;
        while (pready !== 1'b1 && n < 20)
        begin
            @(posedge pclk);
            n++;
        end
        if (n == 20)
        begin
            chk(1'b0, "no ready");
            finish_test();
        end
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        apb(1'b1, a, d, 33'h0, {1'b1, 32'h0});
    endtask
    task automatic rd(input logic [11:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0, {1'b0, e}, {33{1'b1}});
    endtask
    task automatic refused(input logic w, input logic [11:0] a);
        apb(w, a, 32'h0, {1'b1, 32'h0}, {1'b1, 32'h0});
    endtask
    task automatic rst();
        presetn <= 1'b0;
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
    endtask
    // Result watcher: oldest note against each completed transfer
    always @(posedge pclk)
        if (psel && penable && pready)
        begin
            ppc_exp_t e;
            e = expq.pop_front();
            chk((({pslverr, prdata} ^ e.v) & e.m) === 33'h0, "apb answer");
        end
    initial
    begin
        logic [7:0] l;
        logic [7:0] c;
        int q;
        void'($urandom(20));
        rst();
        for (int p = 0; p < 4; p++)
        begin
            c = (p == 3) ? 8'h03 : 8'hff;
            rd(12'(p * 16), {24'h0, c});
            rd(12'(p * 16 + 4), {24'h0, c});
            rd(12'(p * 16 + 8), 32'h0);
        end
        rd(12'h40, 32'h0);
        chk(&pin_oe_n && pin_weak_pullup === 26'h0, "reset pins");
        $display("reset test done");
        for (int t = 0; t < 4; t++)
        begin
            l = 8'($urandom);
            ext_en[23:16] <= (t == 2) ? 8'hff : 8'h0;
            ext_val[23:16] <= ~l;
            wr(12'h20, {24'h0, l});
            wr(12'h24, {32{t[1]}});
            wr(12'h28, {32{t[0]}});
            repeat (2) @(posedge pclk);
            c = (t == 1) ? 8'h00 : (t == 2) ? 8'hff : l;
            chk(pin_oe_n[23:16] === c, "drive enable");
            chk(pin_weak_pullup[23:16] === ((t == 0) ? l : 8'h0), "weak");
            chk((pin_out[23:16] & ~c) === (l & ~c), "drive level");
            repeat (10) @(posedge pclk);
            if (t == 1 || t == 2)
                rd(12'h2c, {24'h0, (t == 1) ? l : ~l});
        end
        $display("type test done");
        wr(12'h10, 32'hf3);
        wr(12'h14, 32'h0);
        wr(12'h18, 32'hff);
        rd(12'h14, 32'h2c);
        rd(12'h18, 32'hdf);
        chk(pin_oe_n[13:10] === 4'b1000, "restricted pins");
        wr(12'h10, 32'hff);
        repeat (10) @(posedge pclk);
        chk(counter0_input === 1'b1 && external_irq0_input === 1'b1, "idle");
        ext_en[10] <= 1'b1;
        @(posedge pclk);
        ext_en[10] <= 1'b0;
        repeat (8) @(posedge pclk);
        chk(counter0_input === 1'b1, "glitch passed");
        ext_en[10] <= 1'b1;
        repeat (10) @(posedge pclk);
        chk(counter0_input === 1'b0, "level lost");
        ext_en[10] <= 1'b0;
        $display("restricted test done");
        ext_en[7:0] <= 8'hff;
        ext_val[7:0] <= 8'hff;
        wr(12'h40, 32'hff);
        rd(12'h40, 32'h3e);
        repeat (8) @(posedge pclk);
        rd(12'h0c, 32'hc1);
        wr(12'h40, 32'h0);
        repeat (8) @(posedge pclk);
        rd(12'h0c, 32'hff);
        $display("disable test done");
        for (int i = 0; i < 8; i++)
        begin
            c = 8'(i);
            wr(12'h44, {24'h0, c});
            rd(12'h44, {24'h0, c});
            q = 26 - c[0] - ((c[2:1] == 2'h1) ? 1 : (c[2:1] == 2'h3) ? 2 : 0);
            rd(12'h48, {23'h0, c[0], 3'h0, 5'(q)});
        end
        ext_en[13] <= 1'b1;
        repeat (10) @(posedge pclk);
        chk(ext_reset_n === 1'b0, "reset pin ignored");
        ext_en[13] <= 1'b0;
        wr(12'h44, 32'h0);
        ext_en[13] <= 1'b1;
        repeat (10) @(posedge pclk);
        chk(ext_reset_n === 1'b1, "reset pin live");
        ext_en[13] <= 1'b0;
        $display("system test done");
        refused(1'b0, 12'h50);
        refused(1'b0, 12'h02);
        refused(1'b1, 12'h0c);
        refused(1'b1, 12'h48);
        pstrb <= 4'h0;
        wr(12'h00, 32'h55);
        pstrb <= 4'hf;
        rd(12'h00, 32'hff);
        $display("refusal test done");
        wr(12'h40, 32'h3e);
        wr(12'h24, 32'h0);
        rst();
        rd(12'h40, 32'h0);
        rd(12'h24, 32'hff);
        chk(&pin_oe_n, "pins after reset");
        $display("second reset test done");
        finish_test();
    end
endmodule
`default_nettype wire
